/* verilog/pin_ctrl_pkg.sv */
// Shared constants for the clock generator control-pin block
package pin_ctrl_pkg;
  // Serial host interface kinds
  typedef enum logic [1:0] {
    iface_i2c,
    iface_spi3,
    iface_spi4
  } iface_type;
  // Level of the bus kind select that picks I2C
  localparam logic i2c_sel_level = 1'b1;
  // Reset values of the status pin outputs and of the core's output enable and reference
  localparam logic irq_n_reset = 1'b1;
  localparam logic lock_ok_reset = 1'b0;
  localparam logic xtal_lost_n_reset = 1'b1;
  localparam logic outputs_on_reset = 1'b0;
  localparam logic [1:0] ref_sel_reset = 2'h0;
  // Synchroniser depth
  localparam int sync_stages = 2;
endpackage

/* verilog/clock_gen_control_pins.sv */
// Control and status pin logic of a multi-output clock generator
// Notes on behaviour
// - Bus select high means I2C, low SPI
// - Data pin: SDA, SDIO, or SDI input
// - Address bit1 in I2C, serial out SPI4
// - Host supplies the one serial clock
// - Address bit0 in I2C, chip select SPI
// - Interrupt driven low on status change
// - Reset returns all state to defaults
// - Clock outputs off during reset
// - Output disable high turns outputs off
// - Lock indicator high when PLL locked
// - Flag crystal signal loss on status output
// - Realign low resets the output dividers
// - Step-down input lowers selected output once
// - Step-up input raises selected output once
// - Manual mode reference chosen by two pins
module clock_gen_control_pins (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pins from the host
  input wire logic i2c_select,
  input wire logic spi_three_wire,
  input wire logic device_reset_n,
  input wire logic addr_bit0_or_chip_select_n,
  input wire logic addr_bit1_in,
  input wire logic serial_data_in,
  input wire logic serial_clock,
  input wire logic output_disable,
  input wire logic divider_realign_n,
  input wire logic freq_step_down,
  input wire logic freq_step_up,
  input wire logic manual_ref_mode,
  input wire logic [1:0] ref_input_sel,
  // From the serial engine
  input wire logic engine_data_out,
  input wire logic engine_data_oe,
  // From the PLL and crystal monitor, plus the host's status acknowledge
  input wire logic pll_locked_raw,
  input wire logic xtal_lost_raw,
  input wire logic status_ack,
  // Pin outputs
  output logic sda_sdio_out,
  output logic sda_sdio_oe,
  output logic addr_bit1_or_serial_out,
  output logic addr_bit1_or_serial_out_oe,
  output logic status_change_irq_n,
  output logic pll_lock_ok,
  output logic xtal_signal_lost_n,
  // To the core
  output pin_ctrl_pkg::iface_type iface_mode,
  output logic serial_clock_sync,
  output logic serial_data_sync,
  output logic chip_select_n_sync,
  output logic [1:0] slave_addr_low,
  output logic core_reset,
  output logic outputs_enabled,
  output logic divider_reset,
  output logic step_down_pulse,
  output logic step_up_pulse,
  output logic [1:0] active_ref
);
  // Pins brought into the clock domain, one synchroniser each
  localparam int n_in = 17;
  localparam int depth = pin_ctrl_pkg::sync_stages;
  logic [n_in-1:0] raw_in;
  wire logic [n_in-1:0] synced;
  logic step_dn_prev_q;
  logic step_up_prev_q;
  logic lock_prev_q;
  logic lost_prev_q;
  logic i2c_s, spi3_s, dev_rst_s, cs_s, a1_s, sdi_s, sclk_s;
  logic oe_s, realign_s, dn_s, up_s, man_s, lock_s, lost_s, ack_s;
  logic [1:0] ref_sel_s;
  logic status_change;

  // Every asynchronous input passes two flip-flops
  assign raw_in = {i2c_select, spi_three_wire, device_reset_n,
                   addr_bit0_or_chip_select_n, addr_bit1_in,
                   serial_data_in, serial_clock, output_disable,
                   divider_realign_n, freq_step_down, freq_step_up,
                   manual_ref_mode, pll_locked_raw, xtal_lost_raw,
                   status_ack, ref_input_sel};

  // One chain per pin; logic reads only the last stage
  // Chains clear to zero, so the device reset reads as held
  // until the pin has crossed, and all it gates stays quiet
  for (genvar b = 0; b < n_in; b++) begin : g_sync
    logic [depth-1:0] chain_q;
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        chain_q <= '0;
      end else begin
        chain_q <= {chain_q[depth-2:0], raw_in[b]};
      end
    end
    assign synced[b] = chain_q[depth-1];
  end
  assign {i2c_s, spi3_s, dev_rst_s, cs_s, a1_s, sdi_s, sclk_s, oe_s,
          realign_s, dn_s, up_s, man_s, lock_s, lost_s, ack_s,
          ref_sel_s} = synced;

  // Any edge of lock or crystal status counts as a change
  // Previous-value flops clear like the chains, so leaving rst
  // never looks like a change
  assign status_change = (lock_s != lock_prev_q) ||
                         (lost_s != lost_prev_q);

  // Interface mode and shared-pin decoding
  // Pins stay undriven while the device reset is seen, which also
  // covers the first edges after rst while the chains read zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      iface_mode <= pin_ctrl_pkg::iface_i2c;
      serial_clock_sync <= 1'b0;
      serial_data_sync <= 1'b0;
      chip_select_n_sync <= 1'b1;
      slave_addr_low <= 2'h0;
      sda_sdio_out <= 1'b0;
      sda_sdio_oe <= 1'b0;
      addr_bit1_or_serial_out <= 1'b0;
      addr_bit1_or_serial_out_oe <= 1'b0;
    end else begin
      // Serial clock and data always reach the engine
      serial_clock_sync <= sclk_s;
      serial_data_sync <= sdi_s;
      if (i2c_s == pin_ctrl_pkg::i2c_sel_level) begin
        iface_mode <= pin_ctrl_pkg::iface_i2c;
        chip_select_n_sync <= 1'b1;
        // Address pins are read only in I2C mode
        slave_addr_low <= {a1_s, cs_s};
        // Open drain: drive only low
        sda_sdio_out <= 1'b0;
        sda_sdio_oe <= dev_rst_s & engine_data_oe & ~engine_data_out;
        addr_bit1_or_serial_out <= 1'b0;
        addr_bit1_or_serial_out_oe <= 1'b0;
      end else begin
        iface_mode <= spi3_s ? pin_ctrl_pkg::iface_spi3
                             : pin_ctrl_pkg::iface_spi4;
        chip_select_n_sync <= cs_s;
        slave_addr_low <= 2'h0;
        sda_sdio_out <= engine_data_out;
        // Three-wire turns the data pin; four-wire uses the A1 pin
        sda_sdio_oe <= dev_rst_s & spi3_s & engine_data_oe & ~cs_s;
        addr_bit1_or_serial_out <= engine_data_out;
        addr_bit1_or_serial_out_oe <= dev_rst_s & ~spi3_s & ~cs_s;
      end
    end
  end

  // Device reset, output enable and divider realignment
  // Outputs stay off until the device reset pin is seen high;
  // realignment is a level that holds the dividers while low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_reset <= 1'b1;
      outputs_enabled <= pin_ctrl_pkg::outputs_on_reset;
      divider_reset <= 1'b0;
    end else begin
      core_reset <= ~dev_rst_s;
      outputs_enabled <= dev_rst_s & ~oe_s;
      divider_reset <= ~realign_s & dev_rst_s;
    end
  end

  // Status outputs and interrupt
  // Lock is shown only while the device is out of reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pll_lock_ok <= pin_ctrl_pkg::lock_ok_reset;
      xtal_signal_lost_n <= pin_ctrl_pkg::xtal_lost_n_reset;
      status_change_irq_n <= pin_ctrl_pkg::irq_n_reset;
      lock_prev_q <= 1'b0;
      lost_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= lock_s;
      lost_prev_q <= lost_s;
      pll_lock_ok <= lock_s & dev_rst_s;
      xtal_signal_lost_n <= ~lost_s;
      // A new change wins over an acknowledge in the same cycle
      if (!dev_rst_s) begin
        status_change_irq_n <= pin_ctrl_pkg::irq_n_reset;
      end else if (status_change) begin
        status_change_irq_n <= 1'b0;
      end else if (ack_s) begin
        status_change_irq_n <= 1'b1;
      end
    end
  end

  // Frequency step requests, one pulse per rising edge
  // A held pin gives one pulse; it must fall before the next step
  // No step is taken while the device reset is seen
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      step_dn_prev_q <= 1'b0;
      step_up_prev_q <= 1'b0;
      step_down_pulse <= 1'b0;
      step_up_pulse <= 1'b0;
    end else begin
      step_dn_prev_q <= dn_s;
      step_up_prev_q <= up_s;
      step_down_pulse <= dn_s & ~step_dn_prev_q & dev_rst_s;
      step_up_pulse <= up_s & ~step_up_prev_q & dev_rst_s;
    end
  end

  // Manual reference selection; held while manual mode is off
  // The two choice bits cross separately, so changing both at
  // once may show a mixed code for one cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_ref <= pin_ctrl_pkg::ref_sel_reset;
    end else if (!dev_rst_s) begin
      active_ref <= pin_ctrl_pkg::ref_sel_reset;
    end else if (man_s) begin
      active_ref <= ref_sel_s;
    end
  end
endmodule

/* tb/pin_ctrl_checker.sv */
// Checker bound to the control-pin block ports
module pin_ctrl_checker (
  input wire logic clock, rst, device_reset_n, output_disable,
  input wire logic freq_step_up, pll_locked_raw, xtal_lost_raw,
  input wire logic status_change_irq_n, pll_lock_ok, xtal_signal_lost_n,
  input wire logic core_reset, outputs_enabled, step_up_pulse,
  input wire logic step_down_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, quiet in reset
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_up_once: assert property (step_up_pulse |=> !step_up_pulse)
    else $error("long up pulse");
  chk_down_once: assert property
    (step_down_pulse |=> !step_down_pulse) else $error("long down pulse");
  chk_step_latency: assert property ($rose(freq_step_up) &&
    !core_reset |-> ##[2:4] step_up_pulse) else $error("no up pulse");
  chk_outputs_off: assert property
    ((output_disable || !device_reset_n)[*4] |-> !outputs_enabled)
    else $error("outputs on");
  chk_reset_core: assert property ((!device_reset_n)[*4] |->
    core_reset && !pll_lock_ok) else $error("reset not held");
  chk_lock_follow: assert property
    ((pll_locked_raw && device_reset_n)[*4] |-> pll_lock_ok)
    else $error("lock not shown");
  chk_xtal_loss: assert property (xtal_lost_raw[*4] |->
    !xtal_signal_lost_n) else $error("loss not shown");
  chk_irq_change: assert property ($changed(xtal_signal_lost_n) &&
    !core_reset |-> !status_change_irq_n) else $error("no interrupt");
endmodule

bind clock_gen_control_pins pin_ctrl_checker i_pin_ctrl_checker (.*);

/* tb/pin_host_model.sv */
// Host-side model: frame clock and interrupt service
module pin_host_model (
  input wire logic clock, frame_n, status_change_irq_n,
  output logic serial_clock = 1'h0, status_ack = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  int waited = 0;
  // Serial clock runs only in a frame; ack comes four cycles late
  always @(negedge clock) begin
    serial_clock <= !frame_n && !serial_clock;
    waited <= status_change_irq_n ? 0 : waited + 1;
    status_ack <= waited == 4;
  end
endmodule

/* tb/clock_gen_control_pins_tb_top.sv */
// Self-checking bench for the control-pin block
module clock_gen_control_pins_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'h0, rst = 1'h1, i2c_select = 1'h1, spi_three_wire = 1'h0;
  logic device_reset_n = 1'h0, addr_bit0_or_chip_select_n = 1'h0;
  logic addr_bit1_in = 1'h1, serial_data_in = 1'h0, output_disable = 1'h0;
  logic divider_realign_n = 1'h1, freq_step_down = 1'h0;
  logic freq_step_up = 1'h0, manual_ref_mode = 1'h0, engine_data_out = 1'h0;
  logic engine_data_oe = 1'h1, pll_locked_raw = 1'h0, xtal_lost_raw = 1'h0;
  logic [1:0] ref_input_sel = 2'h0, slave_addr_low, active_ref;
  logic sda_sdio_out, sda_sdio_oe, addr_bit1_or_serial_out, pll_lock_ok;
  logic addr_bit1_or_serial_out_oe, status_change_irq_n, core_reset;
  logic xtal_signal_lost_n, serial_clock_sync, serial_data_sync;
  logic chip_select_n_sync, outputs_enabled, divider_reset, serial_clock;
  logic step_down_pulse, step_up_pulse, status_ack;
  pin_ctrl_pkg::iface_type iface_mode;
  int n_errors = 0, n_compared = 0, ups = 0, downs = 0, ticks = 0;
  always #10 clock = ~clock;
  clock_gen_control_pins i_clock_gen_control_pins (.*);
  pin_host_model i_pin_host_model (.frame_n(addr_bit0_or_chip_select_n), .*);
  // Count step pulses and cycles with the serial clock high
  always @(posedge clock) begin
    ups += step_up_pulse;
    downs += step_down_pulse;
    ticks += serial_clock_sync;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #5000;
    n_errors++;
    end_of_test;
  end
  // Test sequence
  initial begin
    wt(3);
    chk(outputs_enabled, 2'h0);
    rst = 1'h0;
    wt(5);
    chk({core_reset, outputs_enabled}, 2'h2);
    device_reset_n = 1'h1;
    wt(5);
    chk(iface_mode, pin_ctrl_pkg::iface_i2c);
    chk(slave_addr_low, 2'h2);
    chk({sda_sdio_oe, sda_sdio_out}, 2'h2);
    chk(outputs_enabled, 2'h1);
    {i2c_select, engine_data_out, output_disable} = 3'h3;
    wt(5);
    chk(iface_mode, pin_ctrl_pkg::iface_spi4);
    chk({addr_bit1_or_serial_out_oe, addr_bit1_or_serial_out}, 2'h3);
    chk({sda_sdio_oe, chip_select_n_sync}, 2'h0);
    chk(outputs_enabled, 2'h0);
    {spi_three_wire, output_disable, divider_realign_n} = 3'h4;
    wt(5);
    chk({sda_sdio_oe, sda_sdio_out}, 2'h3);
    chk(divider_reset, 2'h1);
    chk(iface_mode, pin_ctrl_pkg::iface_spi3);
    {addr_bit0_or_chip_select_n, serial_data_in} = 2'h3;
    wt(5);
    chk({ticks > 0, serial_clock_sync}, 2'h2);
    chk({chip_select_n_sync, serial_data_sync}, 2'h3);
    chk({sda_sdio_oe, divider_reset}, 2'h1);
    {divider_realign_n, freq_step_up, freq_step_down} = 3'h7;
    wt(4);
    {freq_step_up, freq_step_down} = 2'h0;
    wt(6);
    chk({ups == 1, downs == 1}, 2'h3);
    pll_locked_raw = 1'h1;
    wt(5);
    chk({pll_lock_ok, status_change_irq_n}, 2'h2);
    {xtal_lost_raw, manual_ref_mode, ref_input_sel} = 4'hf;
    wt(20);
    chk({xtal_signal_lost_n, status_change_irq_n}, 2'h1);
    chk(active_ref, 2'h3);
    device_reset_n = 1'h0;
    wt(5);
    chk({outputs_enabled, pll_lock_ok}, 2'h0);
    end_of_test;
  end
endmodule
